// ===== logic/esfr_pkg.sv
package esfr_pkg;
    localparam int AXI_AW = 8;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STAT   = 8'h04;
    localparam logic [7:0] OFF_AIR    = 8'h08;
    localparam logic [7:0] OFF_LAT    = 8'h0c;
    localparam logic [7:0] OFF_LON    = 8'h10;
    localparam logic [7:0] OFF_SURF   = 8'h14;
    localparam logic [7:0] OFF_IDENT  = 8'h18;
    localparam logic [7:0] OFF_CHR_HI = 8'h1c;
    localparam logic [7:0] OFF_CHR_LO = 8'h20;
    localparam logic [7:0] OFF_ME_HI  = 8'h24;
    localparam logic [7:0] OFF_ME_LO  = 8'h28;
    localparam logic [7:0] OFF_SRCV   = 8'h2c;
    localparam logic [31:0] REG_RST   = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // field widths
    localparam int W_MT = 2;
    localparam int W_TC = 5;
    localparam int W_CA = 3;
    localparam int W_SURV = 2;
    localparam int W_ALT = 12;
    localparam int W_CPR = 17;
    localparam int W_MOV = 7;
    localparam int W_HDG = 7;
    localparam int W_CAT = 3;
    localparam int W_CHR = 24;
    localparam int W_ME = 56;
    localparam int W_CNT = 8;
    // register field positions
    localparam int CTRL_MT_LSB = 0;
    localparam int CTRL_TC_LSB = 4;
    localparam int CTRL_CA_LSB = 12;
    localparam int CTRL_START  = 31;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR  = 2;
    localparam int STAT_CNT_LSB = 8;
    localparam int AIR_SURV_LSB = 0;
    localparam int AIR_NIC = 2;
    localparam int AIR_ALT_LSB = 4;
    localparam int LAT_T = 24;
    localparam int LAT_F = 25;
    localparam int SURF_HV = 8;
    localparam int SURF_HDG_LSB = 16;
    localparam int SV_ALT = 0;
    localparam int SV_POS = 1;
    localparam int SV_SURF = 2;
    localparam int SV_IDENT = 3;
    localparam int SV_CA = 4;
    localparam int ME_HI_W = 24;
    // payload positions, vector index = 56 - last ME bit
    localparam int ME_TC_LSB = 51;
    localparam int ME_SURV_LSB = 49;
    localparam int ME_NIC = 48;
    localparam int ME_ALT_LSB = 36;
    localparam int ME_T = 35;
    localparam int ME_F = 34;
    localparam int ME_LAT_LSB = 17;
    localparam int ME_LON_LSB = 0;
    localparam int ME_MOV_LSB = 44;
    localparam int ME_HV = 43;
    localparam int ME_HDG_LSB = 36;
    localparam int ME_CAT_LSB = 48;
    localparam int ME_CHR_LSB = 0;
    // message kinds
    localparam logic [1:0] MT_AIR   = 2'h0;
    localparam logic [1:0] MT_SURF  = 2'h1;
    localparam logic [1:0] MT_IDENT = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_BUILD = 2'h1,
        ST_SEND  = 2'h3
    } esfr_state_t;
endpackage

// ===== logic/esfr_me_pack.sv
`timescale 1ns/1ps
module esfr_me_pack
    import esfr_pkg::*;
(
    input  wire logic [W_MT-1:0] mt_in,
    input  wire logic [31:0]     ctrl_in,
    input  wire logic [31:0]     air_in,
    input  wire logic [31:0]     lat_in,
    input  wire logic [31:0]     lon_in,
    input  wire logic [31:0]     surf_in,
    input  wire logic [31:0]     ident_in,
    input  wire logic [31:0]     chr_hi_in,
    input  wire logic [31:0]     chr_lo_in,
    input  wire logic [31:0]     srcv_in,
    output logic      [W_ME-1:0] me_out,
    output logic                 ok_out
);
    logic [W_TC-1:0] tc;
    logic [2*W_CPR+1:0] pos;
    logic [W_HDG-1:0] hdg;
    always_comb begin
        tc  = ctrl_in[CTRL_TC_LSB +: W_TC];
        pos = {lat_in[LAT_T], lat_in[LAT_F], lat_in[0 +: W_CPR], lon_in[0 +: W_CPR]};
        // heading only populated when its valid flag holds
        hdg = surf_in[SURF_HV] ? surf_in[SURF_HDG_LSB +: W_HDG] : '0;
        me_out = '0;
        ok_out = 1'b0;
        unique case (mt_in)
            MT_AIR: begin
                me_out = {tc, air_in[AIR_SURV_LSB +: W_SURV], air_in[AIR_NIC],
                          air_in[AIR_ALT_LSB +: W_ALT], pos};
                ok_out = srcv_in[SV_ALT] & srcv_in[SV_POS] & srcv_in[SV_CA];
            end
            MT_SURF: begin
                me_out = {tc, surf_in[0 +: W_MOV], surf_in[SURF_HV], hdg, pos};
                ok_out = srcv_in[SV_SURF] & srcv_in[SV_POS] & srcv_in[SV_CA];
            end
            MT_IDENT: begin
                me_out = {tc, ident_in[0 +: W_CAT], chr_hi_in[0 +: W_CHR],
                          chr_lo_in[0 +: W_CHR]};
                ok_out = srcv_in[SV_IDENT] & srcv_in[SV_CA];
            end
            default: begin
                me_out = '0;
                ok_out = 1'b0;
            end
        endcase
    end
endmodule

// ===== logic/esfr_framer.sv
`timescale 1ns/1ps
module esfr_framer
    import esfr_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              nrst_in,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [AXI_AW-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic                   frame_valid_out,
    input  wire logic              frame_ready_in,
    output logic [W_CA-1:0]        frame_ca_out,
    output logic [W_ME-1:0]        frame_me_out
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic              aw_held;
        logic [AXI_AW-1:0] awaddr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [31:0]       ctrl;
        logic [31:0]       air;
        logic [31:0]       lat;
        logic [31:0]       lon;
        logic [31:0]       surf;
        logic [31:0]       ident;
        logic [31:0]       chr_hi;
        logic [31:0]       chr_lo;
        logic [31:0]       srcv;
        logic              go;
        esfr_state_t       st;
        logic              fvalid;
        logic              fv_d;
        logic [W_CA-1:0]   fca;
        logic [W_ME-1:0]   fme;
        logic              done;
        logic              err;
        logic [W_CNT-1:0]  cnt;
    } esfr_regs_t;

    esfr_regs_t s_reg;
    esfr_regs_t s_next;
    logic [W_ME-1:0] pack_me;
    logic            pack_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // byte-lane merge
    function automatic logic [31:0] esfr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // word-aligned address
    function automatic logic [7:0] esfr_word(input logic [AXI_AW-1:0] a);
        return {a[7:2], 2'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    esfr_me_pack esfr_me_pack_inst (
        .mt_in     (s_reg.ctrl[CTRL_MT_LSB +: W_MT]),
        .ctrl_in   (s_reg.ctrl),
        .air_in    (s_reg.air),
        .lat_in    (s_reg.lat),
        .lon_in    (s_reg.lon),
        .surf_in   (s_reg.surf),
        .ident_in  (s_reg.ident),
        .chr_hi_in (s_reg.chr_hi),
        .chr_lo_in (s_reg.chr_lo),
        .srcv_in   (s_reg.srcv),
        .me_out    (pack_me),
        .ok_out    (pack_ok)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0]  wa;
        logic [7:0]  ra;
        logic [31:0] rd;
        logic        rbad;
        logic        wbad;
        wa = '0;
        ra = '0;
        rd = REG_RST;
        rbad = 1'b0;
        wbad = 1'b0;
        s_next = s_reg;
        // frame valid history for the checks
        s_next.fv_d = s_reg.fvalid;
        // write response retire
        if (s_reg.bvalid && s_axi_bready_in) begin
            s_next.bvalid = 1'b0;
        end
        // address and data taken in either order
        if (s_axi_awvalid_in && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = s_axi_wdata_in;
            s_next.wstrb = s_axi_wstrb_in;
        end
        if (s_next.aw_held && s_next.w_held && !s_reg.bvalid) begin
            wa = esfr_word(s_next.awaddr);
            unique case (wa)
                OFF_CTRL: begin
                    s_next.ctrl = esfr_merge(s_reg.ctrl, s_next.wdata, s_next.wstrb);
                    s_next.ctrl[CTRL_START] = 1'b0;
                    if (s_next.wstrb[3] && s_next.wdata[CTRL_START]) begin
                        s_next.go = 1'b1;
                    end
                end
                OFF_STAT: begin
                    if (s_next.wstrb[0] && s_next.wdata[STAT_DONE]) begin
                        s_next.done = 1'b0;
                    end
                    if (s_next.wstrb[0] && s_next.wdata[STAT_ERR]) begin
                        s_next.err = 1'b0;
                    end
                end
                OFF_AIR:    s_next.air = esfr_merge(s_reg.air, s_next.wdata, s_next.wstrb);
                OFF_LAT:    s_next.lat = esfr_merge(s_reg.lat, s_next.wdata, s_next.wstrb);
                OFF_LON:    s_next.lon = esfr_merge(s_reg.lon, s_next.wdata, s_next.wstrb);
                OFF_SURF:   s_next.surf = esfr_merge(s_reg.surf, s_next.wdata, s_next.wstrb);
                OFF_IDENT:  s_next.ident = esfr_merge(s_reg.ident, s_next.wdata, s_next.wstrb);
                OFF_CHR_HI: s_next.chr_hi = esfr_merge(s_reg.chr_hi, s_next.wdata, s_next.wstrb);
                OFF_CHR_LO: s_next.chr_lo = esfr_merge(s_reg.chr_lo, s_next.wdata, s_next.wstrb);
                OFF_SRCV:   s_next.srcv = esfr_merge(s_reg.srcv, s_next.wdata, s_next.wstrb);
                OFF_ME_HI, OFF_ME_LO: wbad = 1'b0;
                default:    wbad = 1'b1;
            endcase
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wbad ? RESP_SLVERR : RESP_OKAY;
        end
        // read channel
        if (s_reg.rvalid && s_axi_rready_in) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_reg.arready) begin
            ra = esfr_word(s_axi_araddr_in);
            unique case (ra)
                OFF_CTRL:   rd = s_reg.ctrl;
                OFF_STAT: begin
                    rd[STAT_BUSY] = (s_reg.st != ST_IDLE) | s_reg.go;
                    rd[STAT_DONE] = s_reg.done;
                    rd[STAT_ERR] = s_reg.err;
                    rd[STAT_CNT_LSB +: W_CNT] = s_reg.cnt;
                end
                OFF_AIR:    rd = s_reg.air;
                OFF_LAT:    rd = s_reg.lat;
                OFF_LON:    rd = s_reg.lon;
                OFF_SURF:   rd = s_reg.surf;
                OFF_IDENT:  rd = s_reg.ident;
                OFF_CHR_HI: rd = s_reg.chr_hi;
                OFF_CHR_LO: rd = s_reg.chr_lo;
                OFF_SRCV:   rd = s_reg.srcv;
                OFF_ME_HI:  rd[0 +: ME_HI_W] = s_reg.fme[W_ME-1 -: ME_HI_W];
                OFF_ME_LO:  rd = s_reg.fme[31:0];
                default:    rbad = 1'b1;
            endcase
            s_next.rvalid = 1'b1;
            s_next.rdata = rd;
            s_next.rresp = rbad ? RESP_SLVERR : RESP_OKAY;
        end
        // frame builder, done/err sets placed after the STAT clears so a set wins
        unique case (s_reg.st)
            ST_IDLE: begin
                if (s_reg.go) begin
                    s_next.go = 1'b0;
                    if (pack_ok) begin
                        s_next.st = ST_BUILD;
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
            end
            ST_BUILD: begin
                s_next.fme = pack_me;
                s_next.fca = s_reg.ctrl[CTRL_CA_LSB +: W_CA];
                s_next.fvalid = 1'b1;
                s_next.st = ST_SEND;
            end
            ST_SEND: begin
                if (frame_ready_in) begin
                    s_next.fvalid = 1'b0;
                    s_next.done = 1'b1;
                    s_next.cnt = s_reg.cnt + 1'b1;
                    s_next.st = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready_out = s_reg.awready;
    assign s_axi_wready_out = s_reg.wready;
    assign s_axi_bvalid_out = s_reg.bvalid;
    assign s_axi_bresp_out = s_reg.bresp;
    assign s_axi_arready_out = s_reg.arready;
    assign s_axi_rvalid_out = s_reg.rvalid;
    assign s_axi_rdata_out = s_reg.rdata;
    assign s_axi_rresp_out = s_reg.rresp;
    assign frame_valid_out = s_reg.fvalid;
    assign frame_ca_out = s_reg.fca;
    assign frame_me_out = s_reg.fme;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic [W_MT-1:0] ast_mt;
    logic            ast_new;
    assign ast_mt = s_reg.ctrl[CTRL_MT_LSB +: W_MT];
    assign ast_new = s_reg.fvalid && !s_reg.fv_d;

    default clocking ast_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    AST_CA: assert property (ast_new |-> frame_ca_out ==
        $past(s_reg.ctrl[CTRL_CA_LSB +: W_CA]))
        else $error("capability field mismatch");
    AST_SURV: assert property (ast_new && $past(ast_mt) == MT_AIR |->
        frame_me_out[ME_SURV_LSB +: W_SURV] == $past(s_reg.air[AIR_SURV_LSB +: W_SURV]))
        else $error("surveillance status mismatch");
    AST_NIC: assert property (ast_new && $past(ast_mt) == MT_AIR |->
        frame_me_out[ME_NIC] == $past(s_reg.air[AIR_NIC]))
        else $error("supplement flag mismatch");
    AST_ALT: assert property (ast_new && $past(ast_mt) == MT_AIR |->
        frame_me_out[ME_ALT_LSB +: W_ALT] == $past(s_reg.air[AIR_ALT_LSB +: W_ALT]))
        else $error("altitude mismatch");
    AST_TIME: assert property (ast_new && $past(ast_mt) != MT_IDENT |->
        frame_me_out[ME_T] == $past(s_reg.lat[LAT_T]))
        else $error("time mark bit mismatch");
    AST_FMT: assert property (ast_new && $past(ast_mt) != MT_IDENT |->
        frame_me_out[ME_F] == $past(s_reg.lat[LAT_F]))
        else $error("parity bit mismatch");
    AST_CPR: assert property (ast_new && $past(ast_mt) != MT_IDENT |->
        frame_me_out[ME_LAT_LSB +: W_CPR] == $past(s_reg.lat[0 +: W_CPR]) &&
        frame_me_out[ME_LON_LSB +: W_CPR] == $past(s_reg.lon[0 +: W_CPR]))
        else $error("position mismatch");
    AST_MOV: assert property (ast_new && $past(ast_mt) == MT_SURF |->
        frame_me_out[ME_MOV_LSB +: W_MOV] == $past(s_reg.surf[0 +: W_MOV]))
        else $error("movement mismatch");
    AST_HDG: assert property (ast_new && $past(ast_mt) == MT_SURF |->
        frame_me_out[ME_HV] == $past(s_reg.surf[SURF_HV]) &&
        frame_me_out[ME_HDG_LSB +: W_HDG] == ($past(s_reg.surf[SURF_HV]) ?
        $past(s_reg.surf[SURF_HDG_LSB +: W_HDG]) : W_HDG'(0)))
        else $error("heading field mismatch");
    AST_CAT: assert property (ast_new && $past(ast_mt) == MT_IDENT |->
        frame_me_out[ME_CAT_LSB +: W_CAT] == $past(s_reg.ident[0 +: W_CAT]))
        else $error("category mismatch");
    AST_CHR: assert property (ast_new && $past(ast_mt) == MT_IDENT |->
        frame_me_out[ME_CHR_LSB +: 2*W_CHR] ==
        $past({s_reg.chr_hi[0 +: W_CHR], s_reg.chr_lo[0 +: W_CHR]}))
        else $error("identity characters mismatch");
    AST_SRC: assert property (s_reg.st == ST_IDLE && s_reg.go && !pack_ok |=>
        s_reg.err && s_reg.st == ST_IDLE ##1 !frame_valid_out)
        else $error("frame built from invalid source");
    AST_HOLD: assert property (frame_valid_out && !frame_ready_in |=>
        frame_valid_out && $stable(frame_me_out) && $stable(frame_ca_out))
        else $error("frame changed while waiting");
    AST_TC: assert property (ast_new |->
        frame_me_out[ME_TC_LSB +: W_TC] == $past(s_reg.ctrl[CTRL_TC_LSB +: W_TC]))
        else $error("type code mismatch");

    COV_AIR: cover property (ast_new && $past(ast_mt) == MT_AIR);
    COV_SURF: cover property (ast_new && $past(ast_mt) == MT_SURF);
    COV_IDENT: cover property (ast_new && $past(ast_mt) == MT_IDENT);
    COV_STALL: cover property (frame_valid_out && !frame_ready_in ##1 frame_ready_in);
endmodule

// ===== test/esfr_mod_model.sv
`timescale 1ns/1ps
// frame sink for the modulator side, prompt or slow
module esfr_mod_model (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic valid_in,
    input  wire logic slow_in,
    output logic      ready_out
);
    logic [1:0] wait_reg;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_reg <= 2'h0;
        end else if (valid_in && !ready_out) begin
            wait_reg <= wait_reg + 2'h1;
        end else begin
            wait_reg <= 2'h0;
        end
    end
    // slow mode holds off three cycles
    assign ready_out = valid_in && (!slow_in || wait_reg == 2'h3);
endmodule

// ===== test/esfr_framer_tb.sv
`timescale 1ns/1ps
module esfr_framer_tb;
    import esfr_pkg::*;
    typedef struct packed {
        logic [1:0] mt; logic [4:0] tc; logic [2:0] ca; logic [6:0] a; logic b;
        logic [11:0] c; logic t; logic f; logic [16:0] la; logic [16:0] lo; logic [47:0] ch;
    } esfr_row_t;
    logic        clk = 0, nrst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, slow = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0]  ws = 0;
    logic        awr, wr, bv, arr, rv, fv, frdy, got;
    logic [1:0]  br, rr;
    logic [2:0]  fca;
    logic [55:0] fme, e;
    int          num_errors = 0, n_compared = 0, i, k;
    esfr_row_t   r;
    esfr_row_t   rows [7] = '{
        '{MT_AIR, 5'h0b, 3'h0, 7'h0, 1'b1, 12'hc38, 1'b0, 1'b0, 17'h1a5f3, 17'h0c4e1, 48'h0},
        '{MT_AIR, 5'h0c, 3'h7, 7'h1, 1'b0, 12'hfff, 1'b1, 1'b0, 17'h1ffff, 17'h00001, 48'h0},
        '{MT_AIR, 5'h12, 3'h5, 7'h2, 1'b1, 12'h001, 1'b0, 1'b1, 17'h00000, 17'h1ffff, 48'h0},
        '{MT_AIR, 5'h09, 3'h2, 7'h3, 1'b0, 12'h5a5, 1'b1, 1'b1, 17'h10001, 17'h0aaaa, 48'h0},
        '{MT_SURF, 5'h07, 3'h4, 7'h7f, 1'b1, 12'h05a, 1'b1, 1'b0, 17'h0f0f0, 17'h13579, 48'h0},
        '{MT_SURF, 5'h05, 3'h1, 7'h01, 1'b0, 12'h033, 1'b0, 1'b1, 17'h02468, 17'h1e1e1, 48'h0},
        '{MT_IDENT, 5'h04, 3'h6, 7'h4, 1'b0, 12'h0, 1'b0, 1'b0, 17'h0, 17'h0, 48'h0c3a1f2e5d47}};
    logic [6:0]  errs [4] = '{{5'h0f, MT_AIR}, {5'h14, MT_SURF}, {5'h17, MT_IDENT}, {5'h1f, 2'h3}};
    ////////////////////////////////////////////////////////////////////////////////
    esfr_framer esfr_framer_inst (
        .sys_clk_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .frame_valid_out(fv), .frame_ready_in(frdy), .frame_ca_out(fca), .frame_me_out(fme));
    esfr_mod_model esfr_mod_model_inst (
        .clk_in(clk), .nrst_in(nrst), .valid_in(fv), .slow_in(slow), .ready_out(frdy));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
        n_compared++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic hang;
        num_errors++;
        end_sim();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
        int  n;
        logic aw_p, w_p;
        aw_p = 1; w_p = 1;
        awa <= a; wd <= d; ws <= 4'hf; awv <= 1; wv <= 1; bre <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (aw_p && awr) begin aw_p = 0; awv <= 0; end
            if (w_p && wr) begin w_p = 0; wv <= 0; end
            if (bv === 1'b1) begin chk("bresp", 64'(br), 64'(x)); break; end
        end
        if (n == 50) hang();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] x);
        int n;
        ara <= a; arv <= 1; rre <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
            if (rv === 1'b1) begin d = rd; chk("rresp", 64'(rr), 64'(x)); break; end
        end
        if (n == 50) hang();
    endtask
    function automatic logic [55:0] expme(esfr_row_t q);
        case (q.mt)
            MT_AIR:  return {q.tc, q.a[1:0], q.b, q.c, q.t, q.f, q.la, q.lo};
            MT_SURF: return {q.tc, q.a, q.b, q.b ? q.c[6:0] : 7'h0, q.t, q.f, q.la, q.lo};
            default: return {q.tc, q.a[2:0], q.ch};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        repeat (3) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        chk("fv_rst", 64'(fv), 64'h0);
        axr(OFF_STAT, d, RESP_OKAY);
        chk("stat_rst", 64'(d), 64'h0);
        axw(OFF_SRCV, 32'h1f, RESP_OKAY);
        // ordinary frames, one per row
        for (k = 0; k < 7; k++) begin
            r = rows[k];
            e = expme(r);
            slow <= k[0];
            axw(OFF_AIR, {16'h0, r.c, 1'b0, r.b, r.a[1:0]}, RESP_OKAY);
            axw(OFF_LAT, {6'h0, r.f, r.t, 7'h0, r.la}, RESP_OKAY);
            axw(OFF_LON, {15'h0, r.lo}, RESP_OKAY);
            axw(OFF_SURF, {9'h0, r.c[6:0], 7'h0, r.b, 1'b0, r.a}, RESP_OKAY);
            axw(OFF_IDENT, {29'h0, r.a[2:0]}, RESP_OKAY);
            axw(OFF_CHR_HI, {8'h0, r.ch[47:24]}, RESP_OKAY);
            axw(OFF_CHR_LO, {8'h0, r.ch[23:0]}, RESP_OKAY);
            axw(OFF_CTRL, {1'b1, 16'h0, r.ca, 3'h0, r.tc, 2'h0, r.mt}, RESP_OKAY);
            got = 0;
            for (i = 0; i < 60; i++) begin
                @(posedge clk);
                if (fv === 1'b1 && !got) begin
                    got = 1;
                    chk("me", 64'(fme), 64'(e));
                    chk("ca", 64'(fca), 64'(r.ca));
                end
                if (got && fv === 1'b1 && frdy === 1'b1) break;
            end
            if (i == 60) hang();
            axr(OFF_ME_HI, d, RESP_OKAY);
            chk("me_hi", 64'(d), 64'(e[55:32]));
            axr(OFF_ME_LO, d, RESP_OKAY);
            chk("me_lo", 64'(d), 64'(e[31:0]));
            axr(OFF_STAT, d, RESP_OKAY);
            chk("stat", 64'(d[15:0]), 64'({8'(k + 1), 8'h02}));
        end
        // missing sources or illegal kind give no frame
        for (k = 0; k < 4; k++) begin
            axw(OFF_SRCV, {27'h0, errs[k][6:2]}, RESP_OKAY);
            axw(OFF_CTRL, {1'b1, 16'h0, 3'h3, 3'h0, 5'h01, 2'h0, errs[k][1:0]}, RESP_OKAY);
            got = 0;
            repeat (10) begin
                @(posedge clk);
                if (fv !== 1'b0) got = 1;
            end
            chk("no_frame", 64'(got), 64'h0);
            axr(OFF_STAT, d, RESP_OKAY);
            chk("err", 64'({d[15:8], d[2]}), 64'({8'h07, 1'b1}));
            axw(OFF_STAT, 32'h6, RESP_OKAY);
        end
        axw(8'h40, 32'h1, RESP_SLVERR);
        axr(8'h40, d, RESP_SLVERR);
        chk("unmapped", 64'(d), 64'h0);
        // reset in mid-frame drops the frame and clears status
        slow <= 1;
        axw(OFF_SRCV, 32'h1f, RESP_OKAY);
        axw(OFF_CTRL, 32'h8000_0000, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("fv_up", 64'(fv), 64'h1);
        nrst <= 0;
        @(posedge clk);
        chk("mid_rst", 64'({fv, awr, bv, rv}), 64'h0);
        nrst <= 1;
        @(posedge clk);
        axr(OFF_STAT, d, RESP_OKAY);
        chk("stat_mid", 64'(d), 64'h0);
        axr(OFF_ME_LO, d, RESP_OKAY);
        chk("me_mid", 64'(d), 64'h0);
        end_sim();
    end
endmodule
